// >>> dcw_pkg.sv
// Purpose: Shared constants and types for the drive command word decoder.
// Assumes: Drive command word one arrives as a 16-bit word with a telegram type code.
// Notes: Every bit position and mask used by the design lives here; single-bit reset values stay in the modules.

package dcw_pkg;

  // ************************************************************
  // Command word bit positions
  // ************************************************************
  localparam int unsigned CW_RAMP_STOP = 0;  // Low requests ramp stop, rising edge switches on.
  localparam int unsigned CW_COAST_STOP = 1;  // Low requests coast stop.
  localparam int unsigned CW_QUICK_STOP = 2;  // Low requests quick stop.
  localparam int unsigned CW_ENABLE_OP = 3;  // High enables operation.
  localparam int unsigned CW_RG_ENABLE = 4;  // Low forces the ramp generator to zero.
  localparam int unsigned CW_RG_RUN = 5;  // Low freezes the ramp generator.
  localparam int unsigned CW_SETPOINT = 6;  // High enables the setpoint.
  localparam int unsigned CW_FAULT_ACK = 7;  // Rising edge acknowledges faults.
  localparam int unsigned CW_PLC_CTRL = 10;  // High accepts process data.
  localparam int unsigned CW_REVERSE = 11;  // High inverts the setpoint.
  localparam int unsigned CW_MOP_UP = 13;  // High raises the motor potentiometer.
  localparam int unsigned CW_MOP_DOWN = 14;  // High lowers the motor potentiometer.
  localparam int unsigned CW_CDS_BIT0 = 15;  // Command data set select bit 0 under type 20.

  // ************************************************************
  // State word bit positions
  // ************************************************************
  localparam int unsigned SW_READY_ON = 0;  // Ready for switching on.
  localparam int unsigned SW_READY = 1;  // Ready.
  localparam int unsigned SW_OP_ENABLED = 2;  // Operation enabled.
  localparam int unsigned SW_FAULT = 3;  // Fault active.
  localparam int unsigned SW_NO_COAST = 4;  // Coast stop inactive.
  localparam int unsigned SW_NO_QUICK = 5;  // Quick stop inactive.
  localparam int unsigned SW_INHIBITED = 6;  // Switching on inhibited.
  localparam int unsigned SW_PLC_REQ = 9;  // Master control requested.

  // ************************************************************
  // Telegram type codes
  // ************************************************************
  localparam logic [7:0] TG_TYPE_1 = 8'h01;
  localparam logic [7:0] TG_TYPE_2 = 8'h02;
  localparam logic [7:0] TG_TYPE_3 = 8'h03;
  localparam logic [7:0] TG_TYPE_4 = 8'h04;
  localparam logic [7:0] TG_TYPE_7 = 8'h07;
  localparam logic [7:0] TG_TYPE_9 = 8'h09;
  localparam logic [7:0] TG_TYPE_20 = 8'h14;

  // ************************************************************
  // Ownership masks, one bit per word bit
  // ************************************************************
  localparam logic [15:0] CW_PROF_BASIC = 16'h07FF;  // Types 1 to 4, profile bits.
  localparam logic [15:0] CW_VEND_BASIC = 16'hF800;  // Types 1 to 4, vendor bits.
  localparam logic [15:0] CW_PROF_EXT = 16'h0FFF;  // Types 7 and 9, profile bits.
  localparam logic [15:0] CW_VEND_EXT = 16'hF000;  // Types 7 and 9, vendor bits.
  localparam logic [15:0] CW_PROF_T20 = 16'h8FFF;  // Type 20, profile bits.
  localparam logic [15:0] CW_RSVD_T20 = 16'h7000;  // Type 20, reserved bits.
  localparam logic [15:0] SW_PROF_BASIC = 16'h07FF;  // Types 1 to 4, profile bits.
  localparam logic [15:0] SW_VEND_BASIC = 16'hF800;  // Types 1 to 4, vendor bits.
  localparam logic [15:0] SW_PROF_EXT = 16'h3FFF;  // Types 7 and 9, profile bits.
  localparam logic [15:0] SW_VEND_EXT = 16'hC000;  // Types 7 and 9, vendor bits.
  localparam logic [15:0] SW_PROF_T20 = 16'hEFFF;  // Type 20, profile bits.
  localparam logic [15:0] SW_RSVD_T20 = 16'h1000;  // Type 20, reserved bits.
  localparam logic [15:0] CW_ALWAYS_IGNORED = 16'h1300;  // Bits 8, 9 and 12 never act.
  localparam logic [15:0] MASK_NONE = 16'h0000;  // Reset value of every mask.

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] CW_RESET = 16'h0000;  // Accepted command word after reset.
  localparam logic [7:0] TG_RESET = 8'h01;  // Telegram type assumed after reset.

  // Converter state machine, one-hot.
  typedef enum logic [6:0] {
    ST_INHIBIT = 7'b000_0001,  // Switching on inhibited.
    ST_READY_ON = 7'b000_0010,  // Ready for switching on.
    ST_READY = 7'b000_0100,  // Ready, pulses locked.
    ST_RUN = 7'b000_1000,  // Operation enabled.
    ST_RAMP_STOP = 7'b001_0000,  // Braking on the normal ramp.
    ST_QUICK_STOP = 7'b010_0000,  // Braking on the quick-stop ramp.
    ST_FAULT = 7'b100_0000  // Fault reaction, pulses locked.
  } dcw_state_type;

endpackage : dcw_pkg

// >>> dcw_own_if.sv
// Purpose: Carries the telegram type and the bit ownership masks between modules.
// Assumes: One clock domain; the decoder drives, the owner map answers.
// Notes: Masks lag the telegram type by one clock.

`timescale 1ns/1ps
`default_nettype none

interface dcw_own_if;
  logic [7:0] telegram_type;  // Active telegram type code.
  logic [15:0] cw_profile;  // Command word bits that follow the open profile.
  logic [15:0] cw_vendor;  // Command word bits that are vendor-specific.
  logic [15:0] cw_reserved;  // Command word bits that are reserved.
  logic [15:0] sw_profile;  // State word bits that follow the open profile.
  logic [15:0] sw_vendor;  // State word bits that are vendor-specific.
  logic [15:0] sw_reserved;  // State word bits that are reserved.
  logic is_t20;  // Telegram type 20 is active.

  // The decoder side supplies the type and reads the masks.
  modport decoder (
    output telegram_type,
    input cw_profile, cw_vendor, cw_reserved, sw_profile, sw_vendor, sw_reserved, is_t20
  );

  // The owner map reads the type and supplies the masks.
  modport owner (
    input telegram_type,
    output cw_profile, cw_vendor, cw_reserved, sw_profile, sw_vendor, sw_reserved, is_t20
  );
endinterface : dcw_own_if

`default_nettype wire

// >>> dcw_owner_map.sv
// Purpose: Maps the telegram type to ownership masks for both words.
// Assumes: Unknown telegram types use the layout of types 1 to 4.
// Notes: All masks come from flip-flops.

`timescale 1ns/1ps
`default_nettype none

module dcw_owner_map (
  input wire logic i_mclk,
  input wire logic i_nrst,
  dcw_own_if.owner own
);
  import dcw_pkg::*;

  // ************************************************************
  // Type decode
  // ************************************************************
  wire logic is_ext;  // Types 7 and 9.
  wire logic is_t20;  // Type 20.
  assign is_ext = (own.telegram_type == TG_TYPE_7) || (own.telegram_type == TG_TYPE_9);
  assign is_t20 = (own.telegram_type == TG_TYPE_20);

  wire logic [15:0] cw_prof_d;
  wire logic [15:0] cw_vend_d;
  wire logic [15:0] cw_rsvd_d;
  assign cw_prof_d = is_t20 ? CW_PROF_T20 : (is_ext ? CW_PROF_EXT : CW_PROF_BASIC);
  assign cw_vend_d = is_t20 ? MASK_NONE : (is_ext ? CW_VEND_EXT : CW_VEND_BASIC);
  assign cw_rsvd_d = is_t20 ? CW_RSVD_T20 : MASK_NONE;

  wire logic [15:0] sw_prof_d;
  wire logic [15:0] sw_vend_d;
  wire logic [15:0] sw_rsvd_d;
  assign sw_prof_d = is_t20 ? SW_PROF_T20 : (is_ext ? SW_PROF_EXT : SW_PROF_BASIC);
  assign sw_vend_d = is_t20 ? MASK_NONE : (is_ext ? SW_VEND_EXT : SW_VEND_BASIC);
  assign sw_rsvd_d = is_t20 ? SW_RSVD_T20 : MASK_NONE;

  // Registers the masks so that the decoder reads stable values.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      own.cw_profile <= MASK_NONE;
      own.cw_vendor <= MASK_NONE;
      own.cw_reserved <= MASK_NONE;
      own.sw_profile <= MASK_NONE;
      own.sw_vendor <= MASK_NONE;
      own.sw_reserved <= MASK_NONE;
      own.is_t20 <= 1'b0;
    end
    else
    begin
      own.cw_profile <= cw_prof_d;
      own.cw_vendor <= cw_vend_d;
      own.cw_reserved <= cw_rsvd_d;
      own.sw_profile <= sw_prof_d;
      own.sw_vendor <= sw_vend_d;
      own.sw_reserved <= sw_rsvd_d;
      own.is_t20 <= is_t20;
    end
  end
endmodule // dcw_owner_map

`default_nettype wire

// >>> dcw_decoder.sv
// Purpose: Decodes drive command word one into converter commands and state.
// Assumes: A new command word is offered with a one-cycle valid strobe.
// Notes: Word edges are found between successive accepted words.

`timescale 1ns/1ps
`default_nettype none

module dcw_decoder #(
  parameter int unsigned TYPE_WIDTH = 8  // Width of the telegram type code.
) (
  input wire logic i_mclk,  // System clock, 10 MHz.
  input wire logic i_nrst,  // Asynchronous reset, active low.
  input wire logic [15:0] i_cmd_word,  // Drive command word one from the master.
  input wire logic i_cmd_valid,  // One-cycle strobe: a new word has arrived.
  input wire logic [TYPE_WIDTH-1:0] i_telegram_type,  // Active telegram type.
  input wire logic i_fault_event,  // One-cycle pulse: the converter detected a fault.
  input wire logic i_standstill,  // Level: the motor stands still.
  output logic o_pulse_enable,  // Power stage pulses may run.
  output logic o_ramp_force_zero,  // Ramp generator output forced to zero.
  output logic o_ramp_hold,  // Ramp generator output frozen.
  output logic o_ramp_up,  // Ramp generator runs towards the setpoint.
  output logic o_ramp_down,  // Ramp generator brakes on the normal ramp.
  output logic o_ramp_quick,  // Ramp generator brakes on the quick-stop ramp.
  output logic o_reverse,  // Setpoint sign inverted.
  output logic o_mop_up,  // Motor potentiometer raise.
  output logic o_mop_down,  // Motor potentiometer lower.
  output logic o_cds_bit0,  // Command data set select bit 0.
  output logic o_plc_control,  // High from the first accepted word until reset.
  output logic [15:0] o_drive_state_word_one,  // Profile part of state word one.
  output logic [15:0] o_cw_profile_mask,  // Command word profile bits.
  output logic [15:0] o_cw_vendor_mask,  // Command word vendor bits.
  output logic [15:0] o_cw_reserved_mask,  // Command word reserved bits.
  output logic [15:0] o_sw_profile_mask,  // State word profile bits.
  output logic [15:0] o_sw_vendor_mask,  // State word vendor bits.
  output logic [15:0] o_sw_reserved_mask  // State word reserved bits.
);
  import dcw_pkg::*;

  // Refuse type widths too narrow for the type 20 code.
  if (TYPE_WIDTH < 5 || TYPE_WIDTH > 8)
  begin : g_bad_width
    $error("TYPE_WIDTH must lie between 5 and 8.");
  end

  // ************************************************************
  // Ownership map
  // ************************************************************
  dcw_own_if own ();  // Carrier to the ownership map.
  assign own.telegram_type = 8'(i_telegram_type);

  // Instance that turns the telegram type into ownership masks.
  dcw_owner_map u_owner (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .own(own)
  );

  // ************************************************************
  // Word acceptance
  // ************************************************************
  logic [15:0] word_q;  // Last accepted command word.
  logic [15:0] prev_q;  // Word accepted before that.
  logic fresh_q;  // A word was accepted in the previous clock.
  logic t20_prev_q;  // Type 20 was active in the previous clock.
  logic mop_kept_q;  // Type 20 entered from another type; MOTOR_POTENTIOMETER meaning kept.
  logic mop_kept_d;

  wire logic accept;
  assign accept = i_cmd_valid && i_cmd_word[CW_PLC_CTRL];

  // Holds the accepted word and its predecessor for edge detection.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      word_q <= CW_RESET;
      prev_q <= CW_RESET;
      fresh_q <= 1'b0;
    end
    else
    begin
      fresh_q <= accept;
      if (accept)
      begin
        word_q <= i_cmd_word;
        prev_q <= word_q;
      end
    end
  end

  assign mop_kept_d = own.is_t20 ? (mop_kept_q || !t20_prev_q) : 1'b0;

  // Tracks entry into type 20; masks still at reset count as type 20, so a start there keeps none.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      t20_prev_q <= 1'b1;
      mop_kept_q <= 1'b0;
    end
    else
    begin
      t20_prev_q <= own.is_t20 || (own.cw_profile == MASK_NONE);
      mop_kept_q <= mop_kept_d;
    end
  end

  // ************************************************************
  // Effective command bits
  // ************************************************************
  // ignored bits masked.
  wire logic [15:0] usable;  // Bits allowed to act under the active telegram.
  wire logic [15:0] kept;  // Reserved MOTOR_POTENTIOMETER bits brought back after a type change.
  wire logic [15:0] cw;  // Effective command word.
  assign kept = mop_kept_q ? ((16'h0001 << CW_MOP_UP) | (16'h0001 << CW_MOP_DOWN)) : MASK_NONE;
  assign usable = ~CW_ALWAYS_IGNORED & (~own.cw_reserved | kept);
  assign cw = word_q & usable;

  // Decoded command levels and edges.
  wire logic on_cmd;
  wire logic no_coast;
  wire logic no_quick;
  wire logic enable_op;
  wire logic on_rise;
  wire logic ack_rise;
  assign on_cmd = cw[CW_RAMP_STOP];
  assign no_coast = cw[CW_COAST_STOP];
  assign no_quick = cw[CW_QUICK_STOP];
  assign enable_op = cw[CW_ENABLE_OP];
  assign on_rise = fresh_q && on_cmd && !prev_q[CW_RAMP_STOP];
  assign ack_rise = fresh_q && cw[CW_FAULT_ACK] && !prev_q[CW_FAULT_ACK];

  // ************************************************************
  // Fault flag
  // ************************************************************
  logic fault_q;  // Pending fault.
  logic fault_d;
  assign fault_d = i_fault_event || (fault_q && !ack_rise);

  // Holds the pending fault until acknowledged.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fault_q <= 1'b0;
    end
    else
    begin
      fault_q <= fault_d;
    end
  end

  // ************************************************************
  // Converter state machine
  // ************************************************************
  dcw_state_type state_q;
  dcw_state_type state_d;

  // Works out the next converter state; faults take priority.
  always_comb
  begin
    state_d = state_q;
    if (fault_d)
    begin
      state_d = ST_FAULT;
    end
    else
    begin
      unique case (state_q)
        ST_INHIBIT:
        begin
          // Leaves inhibit only after the switch-on command was withdrawn.
          if (!on_cmd && no_coast && no_quick)
          begin
            state_d = ST_READY_ON;
          end
        end
        ST_READY_ON:
        begin
          if (!no_coast || !no_quick)
          begin
            state_d = ST_INHIBIT;
          end
          else if (on_rise)
          begin
            state_d = ST_READY;
          end
        end
        ST_READY:
        begin
          if (!no_coast || !no_quick)
          begin
            state_d = ST_INHIBIT;
          end
          else if (!on_cmd)
          begin
            state_d = ST_READY_ON;
          end
          else if (enable_op)
          begin
            state_d = ST_RUN;
          end
        end
        ST_RUN, ST_RAMP_STOP:
        begin
          if (!no_coast)
          begin
            state_d = ST_INHIBIT;
          end
          else if (!enable_op)
          begin
            state_d = on_cmd ? ST_READY : ST_READY_ON;
          end
          else if (!no_quick)
          begin
            state_d = ST_QUICK_STOP;
          end
          else if (!on_cmd)
          begin
            state_d = i_standstill ? ST_READY_ON : ST_RAMP_STOP;
          end
          else if (state_q == ST_RAMP_STOP && on_rise)
          begin
            state_d = ST_RUN;
          end
        end
        ST_QUICK_STOP:
        begin
          if (!no_coast || !enable_op || i_standstill)
          begin
            state_d = ST_INHIBIT;
          end
        end
        ST_FAULT:
        begin
          if (ack_rise)
          begin
            state_d = on_cmd ? ST_INHIBIT : ST_READY_ON;
          end
        end
        default:
        begin
          state_d = ST_FAULT;
        end
      endcase
    end
  end

  // Advances the converter state.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_q <= ST_INHIBIT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Command outputs
  // ************************************************************
  wire logic running_d;  // Pulses enabled in the next state.
  assign running_d = (state_d == ST_RUN) || (state_d == ST_RAMP_STOP) ||
                     (state_d == ST_QUICK_STOP);
  wire logic mop_ok;  // MOTOR_POTENTIOMETER bits carry meaning now.
  assign mop_ok = !own.is_t20 || mop_kept_q;

  // Registers every command output.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_pulse_enable <= 1'b0;
      o_ramp_force_zero <= 1'b1;
      o_ramp_hold <= 1'b0;
      o_ramp_up <= 1'b0;
      o_ramp_down <= 1'b0;
      o_ramp_quick <= 1'b0;
      o_reverse <= 1'b0;
      o_mop_up <= 1'b0;
      o_mop_down <= 1'b0;
      o_cds_bit0 <= 1'b0;
      o_plc_control <= 1'b0;
    end
    else
    begin
      o_pulse_enable <= running_d;
      o_ramp_force_zero <= !running_d || !cw[CW_RG_ENABLE];
      o_ramp_hold <= running_d && !cw[CW_RG_RUN];
      o_ramp_up <= (state_d == ST_RUN) && cw[CW_SETPOINT];
      o_ramp_down <= (state_d == ST_RAMP_STOP) || ((state_d == ST_RUN) && !cw[CW_SETPOINT]);
      o_ramp_quick <= (state_d == ST_QUICK_STOP);
      o_reverse <= cw[CW_REVERSE];
      o_mop_up <= mop_ok && cw[CW_MOP_UP];
      o_mop_down <= mop_ok && cw[CW_MOP_DOWN];
      o_cds_bit0 <= own.is_t20 && cw[CW_CDS_BIT0];
      o_plc_control <= word_q[CW_PLC_CTRL];
    end
  end

  // ************************************************************
  // State word and masks
  // ************************************************************
  wire logic [15:0] sw_d;
  assign sw_d = (16'((state_q == ST_READY_ON) || (state_q == ST_READY)) << SW_READY_ON) |
                (16'((state_q == ST_READY) || running_d) << SW_READY) |
                (16'(state_q == ST_RUN) << SW_OP_ENABLED) |
                (16'(fault_q) << SW_FAULT) |
                (16'(no_coast) << SW_NO_COAST) |
                (16'(no_quick) << SW_NO_QUICK) |
                (16'(state_q == ST_INHIBIT) << SW_INHIBITED) |
                (16'(1'b1) << SW_PLC_REQ);

  // state word masked to profile bits.
  always_ff @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_drive_state_word_one <= MASK_NONE;
    end
    else
    begin
      o_drive_state_word_one <= sw_d & own.sw_profile;
    end
  end

  assign o_cw_profile_mask = own.cw_profile;
  assign o_cw_vendor_mask = own.cw_vendor;
  assign o_cw_reserved_mask = own.cw_reserved;
  assign o_sw_profile_mask = own.sw_profile;
  assign o_sw_vendor_mask = own.sw_vendor;
  assign o_sw_reserved_mask = own.sw_reserved;
endmodule // dcw_decoder

`default_nettype wire

// >>> dcw_decoder_checker.sv
// Purpose: Port-level timing checks for the drive command word decoder.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Bound to every decoder instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder_checker
  import dcw_pkg::*;
#(
  parameter int unsigned TYPE_WIDTH = 8  // Width of the telegram type code.
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic [15:0] i_cmd_word,
  input wire logic i_cmd_valid,
  input wire logic [TYPE_WIDTH-1:0] i_telegram_type,
  input wire logic i_fault_event,
  input wire logic o_pulse_enable,
  input wire logic o_ramp_force_zero,
  input wire logic o_ramp_up,
  input wire logic o_ramp_quick,
  input wire logic o_reverse,
  input wire logic o_cds_bit0,
  input wire logic [15:0] o_drive_state_word_one,
  input wire logic [15:0] o_cw_profile_mask,
  input wire logic [15:0] o_cw_vendor_mask,
  input wire logic [15:0] o_sw_profile_mask,
  input wire logic [15:0] o_sw_vendor_mask,
  input wire logic [15:0] o_cw_reserved_mask,
  input wire logic [15:0] o_sw_reserved_mask
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // A word is taken only while it asks for master control.
  wire logic acc;
  assign acc = i_cmd_valid && i_cmd_word[10];
  a_fault_cuts_pulses: assert property (i_fault_event |=> !o_pulse_enable)
    else $error("pulses still on after fault");
  a_fault_flag_shown: assert property (i_fault_event |-> ##2 o_drive_state_word_one[SW_FAULT])
    else $error("fault bit missing in state word");
  a_reverse_follows: assert property (acc |-> ##2 o_reverse == $past(i_cmd_word[11], 2))
    else $error("reverse does not follow word");
  a_cds_select: assert property (acc && $stable(i_telegram_type) |-> ##2
    o_cds_bit0 == ($past(i_cmd_word[15], 2) && $past(i_telegram_type, 2) == TG_TYPE_20))
    else $error("data set select wrong");
  a_coast_cuts: assert property (acc && !i_cmd_word[1] |-> ##2
    !o_pulse_enable && !o_drive_state_word_one[SW_NO_COAST])
    else $error("pulses on after coast stop");
  a_zero_forced: assert property (acc && !i_cmd_word[4] |-> ##2 o_ramp_force_zero)
    else $error("ramp not forced to zero");
  a_quick_brake: assert property (acc && o_ramp_up && i_cmd_word[3:0] == 4'hB
    && !i_fault_event && !$past(acc) ##1 !i_fault_event
    |=> o_ramp_quick && o_pulse_enable && !o_drive_state_word_one[SW_NO_QUICK])
    else $error("quick stop not braking");
  a_run_shown: assert property (o_ramp_up |=> o_drive_state_word_one[SW_OP_ENABLED])
    else $error("operation enabled bit missing");
  a_basic_masks: assert property (i_telegram_type == TG_TYPE_1 |=>
    o_cw_profile_mask == CW_PROF_BASIC && o_cw_vendor_mask == CW_VEND_BASIC
    && o_sw_profile_mask == SW_PROF_BASIC && o_sw_vendor_mask == SW_VEND_BASIC)
    else $error("basic masks wrong");
  a_ext_masks: assert property (i_telegram_type == TG_TYPE_7 |=>
    o_cw_profile_mask == CW_PROF_EXT && o_cw_vendor_mask == CW_VEND_EXT
    && o_sw_profile_mask == SW_PROF_EXT && o_sw_vendor_mask == SW_VEND_EXT)
    else $error("extended masks wrong");
  a_t20_reserved: assert property (i_telegram_type == TG_TYPE_20 |=>
    o_cw_reserved_mask == CW_RSVD_T20 && o_sw_reserved_mask == SW_RSVD_T20)
    else $error("reserved masks wrong");
endmodule  // dcw_decoder_checker
bind dcw_decoder dcw_decoder_checker #(.TYPE_WIDTH(TYPE_WIDTH)) u_chk (.*);
`default_nettype wire

// >>> dcw_plc_model.sv
// Purpose: Behavioural fieldbus master sending drive command word one.
// Assumes: Words are driven 1 ns after a clock edge, one cycle each.
// Notes: Idle data lines show the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none
module dcw_plc_model (
  input wire logic i_mclk,
  output logic [15:0] o_word,
  output logic o_valid
);
  initial
  begin
    o_word = 16'h0000;
    o_valid = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    repeat ($urandom % 3) @(posedge i_mclk);
    @(posedge i_mclk) #1 o_word = w;
    o_valid = 1'b1;
    @(posedge i_mclk) #1 o_valid = 1'b0;
    o_word = ~w;
  endtask
endmodule  // dcw_plc_model
`default_nettype wire

// >>> dcw_decoder_tb.sv
// Purpose: Self-checking bench for the drive command word decoder.
// Assumes: Flags settle within four clocks of each stimulus step.
// Notes: Steps carry their expected flags; a monitor compares them.
`timescale 1ns/1ps
`default_nettype none
module dcw_decoder_tb;
  import dcw_pkg::*;
  typedef struct packed {
    logic [1:0] op;  // 0 word, 1 fault, 2 standstill, 3 telegram type.
    logic [15:0] w;
    logic x;  // Stop states: skip force-zero, hold and inhibit bits.
    logic [10:0] f;
    logic [1:0] s;  // Fault and inhibited bits of the state word.
  } dcw_step_type;
  dcw_step_type steps [30] = '{
    '{2'h2,16'h0000,1'h0,11'h200,2'h1}, '{2'h0,16'h0406,1'h0,11'h201,2'h0},
    '{2'h0,16'h040F,1'h0,11'h741,2'h0}, '{2'h0,16'h047F,1'h0,11'h481,2'h0},
    '{2'h0,16'h0C7F,1'h0,11'h491,2'h0}, '{2'h0,16'h045F,1'h0,11'h581,2'h0},
    '{2'h0,16'h046F,1'h0,11'h681,2'h0}, '{2'h0,16'h043F,1'h0,11'h441,2'h0},
    '{2'h0,16'h0000,1'h0,11'h441,2'h0}, '{2'h0,16'h247F,1'h0,11'h489,2'h0},
    '{2'h0,16'h447F,1'h0,11'h485,2'h0}, '{2'h0,16'h047B,1'h1,11'h421,2'h0},
    '{2'h2,16'h0000,1'h0,11'h201,2'h1}, '{2'h0,16'h047E,1'h0,11'h201,2'h0},
    '{2'h0,16'h047F,1'h0,11'h481,2'h0}, '{2'h0,16'h047E,1'h1,11'h441,2'h0},
    '{2'h2,16'h0000,1'h0,11'h201,2'h0}, '{2'h0,16'h047F,1'h0,11'h481,2'h0},
    '{2'h0,16'h0477,1'h0,11'h201,2'h0}, '{2'h0,16'h047F,1'h0,11'h481,2'h0},
    '{2'h0,16'h047D,1'h0,11'h201,2'h1}, '{2'h1,16'h0000,1'h0,11'h201,2'h2},
    '{2'h0,16'h047F,1'h0,11'h201,2'h2}, '{2'h0,16'h04FF,1'h0,11'h201,2'h1},
    '{2'h3,16'h0014,1'h0,11'h201,2'h1}, '{2'h0,16'h847E,1'h0,11'h203,2'h0},
    '{2'h0,16'h247E,1'h0,11'h209,2'h0}, '{2'h0,16'h047E,1'h0,11'h201,2'h0},
    '{2'h3,16'h0007,1'h0,11'h201,2'h0}, '{2'h0,16'h847E,1'h0,11'h201,2'h0}};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] ttype = 8'h01;
  logic fault = 1'b0;
  logic stand = 1'b0;
  wire logic [15:0] word;
  wire logic valid;
  wire logic [10:0] flg;
  wire logic [15:0] sw;
  int error_cnt = 0;
  int n_tests = 0;
  dcw_step_type q[$];
  event smp;
  dcw_plc_model plc (.i_mclk(mclk), .o_word(word), .o_valid(valid));
  dcw_decoder #(.TYPE_WIDTH(8)) DUT (
    .i_mclk(mclk), .i_nrst(nrst), .i_cmd_word(word), .i_cmd_valid(valid),
    .i_telegram_type(ttype), .i_fault_event(fault), .i_standstill(stand),
    .o_pulse_enable(flg[10]), .o_ramp_force_zero(flg[9]), .o_ramp_hold(flg[8]),
    .o_ramp_up(flg[7]), .o_ramp_down(flg[6]), .o_ramp_quick(flg[5]), .o_reverse(flg[4]),
    .o_mop_up(flg[3]), .o_mop_down(flg[2]), .o_cds_bit0(flg[1]), .o_plc_control(flg[0]),
    .o_drive_state_word_one(sw), .o_cw_profile_mask(), .o_cw_vendor_mask(),
    .o_cw_reserved_mask(), .o_sw_profile_mask(), .o_sw_vendor_mask(), .o_sw_reserved_mask());
  always #50 mclk = ~mclk;
  task automatic cmp_flags(input logic [10:0] e, input logic [10:0] m);
    n_tests++;
    if ((flg & m) !== (e & m))
    begin
      error_cnt++;
      $display("ERROR flags expected %h seen %h", e & m, flg & m);
    end
  endtask
  task automatic cmp_sw(input logic [1:0] e, input logic [1:0] m);
    n_tests++;
    if (({sw[3], sw[6]} & m) !== (e & m))
    begin
      error_cnt++;
      $display("ERROR state_bits expected %h seen %h", e & m, {sw[3], sw[6]} & m);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // The monitor takes the oldest note whenever a settled result is flagged.
  always @(smp)
  begin
    dcw_step_type e;
    e = q.pop_front();
    cmp_flags(e.f, e.x ? 11'h4FF : 11'h7FF);
    cmp_sw(e.s, e.x ? 2'h2 : 2'h3);
  end
  initial
  begin
    void'($urandom(67));
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
    foreach (steps[i])
    begin
      case (steps[i].op)
        2'h0: plc.send(steps[i].w | (16'($urandom) & CW_ALWAYS_IGNORED));
        2'h1:
        begin
          @(posedge mclk) #1 fault = 1'b1;
          @(posedge mclk) #1 fault = 1'b0;
        end
        2'h2:
        begin
          @(posedge mclk) #1 stand = 1'b1;
          @(posedge mclk) #1 stand = 1'b0;
        end
        default: @(posedge mclk) #1 ttype = steps[i].w[7:0];
      endcase
      q.push_back(steps[i]);
      repeat (4) @(posedge mclk);
      #2 ->smp;
    end
    @(posedge mclk);
    test_done();
  end
  // A hang is cut short well beyond the expected run length.
  initial
  begin
    repeat (3000) @(posedge mclk);
    error_cnt++;
    test_done();
  end
endmodule  // dcw_decoder_tb
`default_nettype wire
